// file: flash_pkg.sv
// Constants, register map and carrier types of the flash protection and status block.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package flash_pkg;

  localparam int         ADDR_W      = 8;
  // Register indices; byte address is four times the index
  localparam logic [3:0] CONFIG_IDX  = 4'h3;
  localparam logic [3:0] PROT_IDX    = 4'h4;
  localparam logic [3:0] STATUS_IDX  = 4'h5;
  localparam logic [3:0] COMMAND_IDX = 4'h6;
  localparam logic [3:0] ARRAY_IDX   = 4'h8;

  // Status register fields
  localparam int ST_BUF_EMPTY = 7;
  localparam int ST_ALL_CMPL  = 6;
  localparam int ST_PROT_VIOL = 5;
  localparam int ST_ACC_ERR   = 4;
  localparam int ST_BLANK     = 2;
  localparam int ST_FAIL      = 1;
  localparam int ST_DONE      = 0;

  // Protection register fields
  localparam int PR_OPEN  = 7;
  localparam int PR_HOFF  = 5;
  localparam int PR_HS_LO = 3;
  localparam int PR_LOFF  = 2;
  localparam int PR_LS_LO = 0;

  // Config register fields
  localparam int         CFG_BUF_IE  = 7;
  localparam int         CFG_CMPL_IE = 6;
  localparam int         CFG_SPECIAL = 0;
  localparam logic [7:0] CFG_MASK    = 8'hC1;

  localparam logic [7:0] PROT_RST   = 8'hFF;
  localparam logic [7:0] STATUS_RST = 8'hC1;
  localparam logic [7:0] CONFIG_RST = 8'h00;

  // Command codes
  localparam logic [7:0] CMD_MASK    = 8'h65;
  localparam logic [7:0] CMD_VERIFY  = 8'h05;
  localparam logic [7:0] CMD_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_SECTOR  = 8'h40;
  localparam logic [7:0] CMD_MASS    = 8'h41;

  // Protected ranges
  localparam logic [0:3][15:0] HIGH_BASE = {16'hF800, 16'hF000, 16'hE000, 16'hC000};
  localparam logic [15:0]      LOW_BASE  = 16'h4000;
  localparam logic [0:3][15:0] LOW_END   = {16'h43FF, 16'h47FF, 16'h4FFF, 16'h5FFF};

  // Allowed scenario moves, one bit per target scenario
  localparam logic [0:7][7:0] SCEN_ALLOW = {8'h0F, 8'h0A, 8'h0C, 8'h08,
                                            8'h18, 8'h3C, 8'h5A, 8'hFF};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] addr;
  } cmd_t;

endpackage

// file: scenario_gate.sv
// Protection scenario decode and the protection-only-grows move check.
// Assumes both bytes use the protection register layout.
`timescale 1ns/1ps
module scenario_gate import flash_pkg::*; (
  input  wire logic [7:0] cur,
  input  wire logic [7:0] nxt,
  output logic [2:0]      cur_scen,
  output logic            allowed
);

  // Polarity, low off, high off form the scenario index
  function automatic logic [2:0] scen(input logic [7:0] p);
    return {p[PR_OPEN], p[PR_LOFF], p[PR_HOFF]};
  endfunction

  assign cur_scen = scen(cur);
  assign allowed  = SCEN_ALLOW[cur_scen][scen(nxt)];

endmodule // scenario_gate

// file: prot_map.sv
// Decides whether a command aimed at an address hits protected flash.
// Assumes a 16-bit flash address space; purely combinational.
`timescale 1ns/1ps
module prot_map import flash_pkg::*; (
  input  wire logic [7:0]  prot,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  code,
  output logic             blocked
);

  logic high_in;
  logic low_in;
  logic high_sel;
  logic low_sel;
  logic in_any;

  always_comb begin
    high_in  = addr >= HIGH_BASE[prot[PR_HS_LO +: 2]];
    low_in   = (addr >= LOW_BASE) && (addr <= LOW_END[prot[PR_LS_LO +: 2]]);
    high_sel = ~prot[PR_HOFF];
    low_sel  = ~prot[PR_LOFF];
    in_any   = (high_sel & high_in) | (low_sel & low_in);
    if (code == CMD_MASS) begin
      // Mass erase fails whenever any byte is protected
      blocked = prot[PR_OPEN] ? (high_sel | low_sel) : 1'b1;
    end else if (code == CMD_PROGRAM || code == CMD_SECTOR) begin
      blocked = prot[PR_OPEN] ? in_any : ~in_any;
    end else begin
      blocked = 1'b0;
    end
  end

endmodule // prot_map

// file: flash_protect_status.sv
// Protection register, command write sequence and status flags of a flash controller.
// Assumes an AXI4-Lite master on aclk and a command engine on the same clock.
`timescale 1ns/1ps
module flash_protect_status import flash_pkg::*; (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              nv_valid,
  input  wire logic [7:0]        nv_prot,
  input  wire logic              eng_take,
  input  wire logic              eng_busy,
  input  wire logic              verify_done,
  input  wire logic              verify_erased,
  input  wire logic              stop_req,
  output logic                   cmd_valid,
  output cmd_t                   cmd,
  output logic                   irq
);

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_ADDR = 3'b010,
    SEQ_CMD  = 3'b100
  } seq_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  widx;
    logic        wbad;
    logic [31:0] wdata;
    logic [1:0]  wstrb;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  prot;
    logic        loaded;
    logic [7:0]  cfg;
    logic        buf_empty;
    logic        all_cmpl;
    logic        prot_viol;
    logic        acc_err;
    logic        blank;
    logic        fail;
    logic        done;
    seq_t        seq;
    logic [15:0] seq_addr;
    logic [7:0]  seq_code;
    logic        cmd_valid;
    cmd_t        cmd;
    logic        irq;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  logic [7:0]  wd;
  logic        wr_go;
  logic        wr_map;
  logic        wr_cfg;
  logic        wr_prot;
  logic        wr_stat;
  logic        wr_cmd;
  logic        wr_arr;
  logic [7:0]  prot_new;
  logic        prot_ok;
  logic [2:0]  scen_now;
  logic [7:0]  code_in;
  logic        code_legal;
  logic        blocked;
  logic        special;
  logic        launch;
  logic        acc_set;
  logic        pv_set;
  logic [7:0]  status_rd;
  logic [7:0]  rd_byte;
  logic        rd_map;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a[7:6] == 2'h0) && (a[5:2] == CONFIG_IDX || a[5:2] == PROT_IDX ||
           a[5:2] == STATUS_IDX || a[5:2] == COMMAND_IDX || a[5:2] == ARRAY_IDX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode and protection helpers

  assign wd      = s_q.wdata[7:0];
  assign special = s_q.cfg[CFG_SPECIAL];
  assign wr_go   = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
  assign wr_map  = wr_go & ~s_q.wbad;
  assign wr_cfg  = wr_map & s_q.wstrb[0] & (s_q.widx == CONFIG_IDX);
  assign wr_prot = wr_map & s_q.wstrb[0] & (s_q.widx == PROT_IDX);
  assign wr_stat = wr_map & s_q.wstrb[0] & (s_q.widx == STATUS_IDX);
  assign wr_cmd  = wr_map & s_q.wstrb[0] & (s_q.widx == COMMAND_IDX);
  // An array write needs the whole 16-bit word
  assign wr_arr  = wr_map & (&s_q.wstrb) & (s_q.widx == ARRAY_IDX);
  assign code_in = wd & CMD_MASK;
  assign code_legal = (code_in == CMD_VERIFY) || (code_in == CMD_PROGRAM) ||
                      (code_in == CMD_SECTOR) || (code_in == CMD_MASS);

  // Size fields keep their old value unless the matching off bit is set
  assign prot_new = {wd[7:6], wd[PR_HOFF],
                     s_q.prot[PR_HOFF] ? wd[PR_HS_LO +: 2] : s_q.prot[PR_HS_LO +: 2],
                     wd[PR_LOFF],
                     s_q.prot[PR_LOFF] ? wd[PR_LS_LO +: 2] : s_q.prot[PR_LS_LO +: 2]};

  scenario_gate u_gate (
    .cur      (s_q.prot),
    .nxt      (prot_new),
    .cur_scen (scen_now),
    .allowed  (prot_ok)
  );

  prot_map u_map (
    .prot    (s_q.prot),
    .addr    (s_q.seq_addr),
    .code    (code_in),
    .blocked (blocked)
  );

  // Fail and done are hidden outside special modes; bit 3 is always zero
  assign status_rd = {s_q.buf_empty, s_q.all_cmpl, s_q.prot_viol, s_q.acc_err, 1'b0, s_q.blank,
                      s_q.fail & special, s_q.done & special};

  always_comb begin
    rd_map  = mapped(araddr);
    rd_byte = 8'h00;
    case (araddr[5:2])
      CONFIG_IDX:  rd_byte = s_q.cfg;
      PROT_IDX:    rd_byte = s_q.prot;
      STATUS_IDX:  rd_byte = status_rd;
      COMMAND_IDX: rd_byte = (s_q.seq == SEQ_CMD) ? s_q.seq_code : 8'h00;
      default:     rd_byte = 8'h00;
    endcase
    if (!rd_map) begin
      rd_byte = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d     = s_q;
    launch  = 1'b0;
    acc_set = 1'b0;
    pv_set  = 1'b0;

    // AXI write channels; address and data may arrive in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.widx   = awaddr[5:2];
      s_d.wbad   = ~mapped(awaddr);
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb[1:0];
    end
    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = s_q.wbad ? RESP_SLVERR : RESP_OKAY;
    end else if (bready && s_q.bvalid) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
    s_d.wready  = ~s_d.w_got & ~s_d.bvalid;

    // AXI read channel
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = {24'h000000, rd_byte};
      s_d.rresp  = rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rready && s_q.rvalid) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = ~s_d.rvalid;

    if (wr_cfg) begin
      s_d.cfg = wd & CFG_MASK;
    end

    // Protection writes before the nonvolatile image loads are dropped so it cannot be overtaken
    if (!s_q.loaded) begin
      if (nv_valid) begin
        s_d.prot   = nv_prot;
        s_d.loaded = 1'b1;
      end
    end else if (wr_prot && prot_ok) begin
      s_d.prot = prot_new;
    end

    // Command write sequence
    case (s_q.seq)
      SEQ_IDLE: begin
        if (wr_arr) begin
          if (s_q.wdata[0]) begin
            acc_set = 1'b1;
          end else begin
            s_d.seq      = SEQ_ADDR;
            s_d.seq_addr = s_q.wdata[15:0];
          end
        end else if (wr_cmd) begin
          acc_set = 1'b1;
        end else if (wr_stat && wd[ST_BUF_EMPTY] && s_q.buf_empty) begin
          // Nothing to launch; treated as a sequence violation
          acc_set = 1'b1;
        end
      end
      SEQ_ADDR: begin
        if (wr_cmd) begin
          if (!code_legal) begin
            acc_set = 1'b1;
          end else if (blocked) begin
            pv_set  = 1'b1;
            s_d.seq = SEQ_IDLE;
          end else begin
            s_d.seq      = SEQ_CMD;
            s_d.seq_code = code_in;
          end
        end else if (wr_arr || wr_stat) begin
          acc_set = 1'b1;
        end
      end
      SEQ_CMD: begin
        if (wr_stat) begin
          if (!wd[ST_BUF_EMPTY]) begin
            acc_set = 1'b1;
          end else if (s_q.buf_empty && !s_q.prot_viol && !s_q.acc_err && !s_q.fail) begin
            launch  = 1'b1;
            s_d.seq = SEQ_IDLE;
          end else begin
            s_d.seq = SEQ_IDLE;
          end
        end else if (wr_arr || wr_cmd) begin
          acc_set = 1'b1;
        end
      end
      default: begin
        s_d.seq = SEQ_IDLE;
      end
    endcase
    if (acc_set) begin
      s_d.seq = SEQ_IDLE;
    end
    if (stop_req && !s_q.all_cmpl) begin
      acc_set = 1'b1;
    end

    // Command buffer towards the engine
    if (launch) begin
      s_d.cmd_valid = 1'b1;
      s_d.cmd       = '{code: s_q.seq_code, addr: s_q.seq_addr};
      s_d.buf_empty = 1'b0;
    end else if (eng_take && s_q.cmd_valid) begin
      s_d.cmd_valid = 1'b0;
      s_d.buf_empty = 1'b1;
    end

    // Complete flag needs an empty buffer and an idle engine
    if (launch) begin
      s_d.all_cmpl = 1'b0;
    end else if (s_q.buf_empty && !s_q.cmd_valid && !eng_busy) begin
      s_d.all_cmpl = 1'b1;
    end

    // Sticky flags, then done from the idle engine; a set in the same cycle beats the clear
    s_d.prot_viol = (s_q.prot_viol & ~(wr_stat & wd[ST_PROT_VIOL])) | pv_set;
    s_d.acc_err   = (s_q.acc_err & ~(wr_stat & wd[ST_ACC_ERR])) | acc_set;
    s_d.fail      = (s_q.fail & ~(wr_stat & wd[ST_FAIL] & special)) |
                    (special & verify_done & ~verify_erased);
    if (verify_done && verify_erased) begin
      s_d.blank = 1'b1;
    end else if (launch) begin
      s_d.blank = 1'b0;
    end
    s_d.done = ~eng_busy;

    s_d.irq = (s_d.buf_empty & s_d.cfg[CFG_BUF_IE]) |
              (s_d.all_cmpl & s_d.cfg[CFG_CMPL_IE]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q           <= '0;
      s_q.prot      <= PROT_RST;
      s_q.cfg       <= CONFIG_RST;
      s_q.buf_empty <= STATUS_RST[ST_BUF_EMPTY];
      s_q.all_cmpl  <= STATUS_RST[ST_ALL_CMPL];
      s_q.done      <= STATUS_RST[ST_DONE];
      s_q.seq       <= SEQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready   = s_q.awready;
  assign wready    = s_q.wready;
  assign bvalid    = s_q.bvalid;
  assign bresp     = s_q.bresp;
  assign arready   = s_q.arready;
  assign rvalid    = s_q.rvalid;
  assign rdata     = s_q.rdata;
  assign rresp     = s_q.rresp;
  assign cmd_valid = s_q.cmd_valid;
  assign cmd       = s_q.cmd;
  assign irq       = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_launch_done;
    !s_q.buf_empty && !s_q.all_cmpl && s_q.cmd_valid && s_q.seq == SEQ_IDLE;
  endsequence

  sequence s_aborted;
    s_q.acc_err && s_q.seq == SEQ_IDLE;
  endsequence

  property p_prot_drop;
    s_q.loaded && wr_prot && !prot_ok |=> s_q.prot == $past(s_q.prot);
  endproperty
  a_prot_drop: assert property (p_prot_drop) else $error("protection write not dropped");

  property p_prot_take;
    s_q.loaded && wr_prot && prot_ok |=> s_q.prot == $past(prot_new);
  endproperty
  a_prot_take: assert property (p_prot_take) else $error("allowed protection write lost");

  property p_launch;
    launch |=> s_launch_done;
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not clear flags");

  property p_abort;
    s_q.seq != SEQ_IDLE && wr_stat && !wd[ST_BUF_EMPTY] |=> s_aborted;
  endproperty
  a_abort: assert property (p_abort) else $error("zero to buffer flag did not abort");

  // A config write in the same cycle may drop the enable
  property p_irq;
    s_q.buf_empty && s_q.cfg[CFG_BUF_IE] && !launch && !wr_cfg |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("buffer empty interrupt missing");

  property p_viol_block;
    s_q.prot_viol |-> !launch ##1 !$rose(s_q.cmd_valid);
  endproperty
  a_viol_block: assert property (p_viol_block) else $error("launch while violation set");

  property p_stop;
    stop_req && !s_q.all_cmpl |=> s_q.acc_err;
  endproperty
  a_stop: assert property (p_stop) else $error("stop during command not flagged");

  property p_blank;
    launch && !(verify_done && verify_erased) |=> !s_q.blank;
  endproperty
  a_blank: assert property (p_blank) else $error("blank flag kept across launch");

  property p_fail;
    special && verify_done && !verify_erased |=> s_q.fail ##1 (s_q.fail || $past(wr_stat));
  endproperty
  a_fail: assert property (p_fail) else $error("fail flag not set on verify miss");

  property p_done;
    special && eng_busy && !wr_cfg |=> !status_rd[ST_DONE];
  endproperty
  a_done: assert property (p_done) else $error("done flag high while engine active");

endmodule // flash_protect_status

// file: engine_model.sv
// Behavioural flash command engine that fetches from the block's command buffer.
// Assumes the block's clock and reset; slow and erased are set by the bench.
`timescale 1ns/1ps
module engine_model import flash_pkg::*; #(
  parameter int TAKE_DLY = 4,
  parameter int BUSY_LEN = 20
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic cmd_valid,
  input  wire cmd_t cmd,
  input  wire logic slow,
  input  wire logic erased,
  output logic      eng_take,
  output logic      eng_busy,
  output logic      verify_done,
  output logic      verify_erased
);
  int         wait_q;
  int         busy_q;
  logic [7:0] code_q;
  always_ff @(posedge aclk) begin
    eng_take    <= 1'b0;
    verify_done <= 1'b0;
    // Result toggles outside the done pulse so no stale value can pass
    verify_erased <= ~verify_erased;
    if (!aresetn) begin
      eng_busy      <= 1'b0;
      wait_q        <= 0;
      verify_erased <= 1'b0;
    end else if (eng_busy) begin
      busy_q <= busy_q - 1;
      if (busy_q == 1) begin
        verify_done   <= (code_q == CMD_VERIFY);
        verify_erased <= erased;
      end
      if (busy_q == 0) begin
        eng_busy <= 1'b0;
      end
    end else if (cmd_valid && !eng_take) begin
      wait_q <= wait_q + 1;
      // Busy rises with the fetch pulse
      if (wait_q >= (slow ? TAKE_DLY : 0)) begin
        eng_take <= 1'b1;
        eng_busy <= 1'b1;
        busy_q   <= BUSY_LEN;
        code_q   <= cmd.code;
        wait_q   <= 0;
      end
    end
  end
endmodule // engine_model

// file: test_flash_protect_status.sv
// Self-checking bench of the flash protection and status block.
// Assumes the package register map; an engine model serves the command buffer.
`timescale 1ns/1ps
module test_flash_protect_status import flash_pkg::*;;
  localparam logic [7:0] A_CF = {2'b00, CONFIG_IDX, 2'b00};
  localparam logic [7:0] A_PR = {2'b00, PROT_IDX, 2'b00};
  localparam logic [7:0] A_ST = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [7:0] A_CM = {2'b00, COMMAND_IDX, 2'b00};
  localparam logic [7:0] A_AR = {2'b00, ARRAY_IDX, 2'b00};
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, nv_valid = 1'b0, stop_req = 1'b0;
  logic        slow = 1'b0, erased = 1'b1, spc = 1'b0, hit;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, nv_prot = 8'hFF, nv, w8, e, c;
  logic [31:0] wdata = 32'h0, rdv, rdata, r;
  logic [3:0]  wstrb = 4'hF;
  logic [15:0] pa;
  logic [1:0]  rsp, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, cmd_valid, irq;
  logic        eng_take, eng_busy, verify_done, verify_erased;
  cmd_t        cmd;
  int          seed = 3286, st, n_compared = 0, num_errors = 0;
  logic [7:0]  allow [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
  logic [15:0] hb [4] = '{16'hF800, 16'hF000, 16'hE000, 16'hC000};
  logic [15:0] le [4] = '{16'h43FF, 16'h47FF, 16'h4FFF, 16'h5FFF};
  logic [7:0]  codes [7] = '{8'h05, 8'h20, 8'h40, 8'h41, 8'h01, 8'h60, 8'h25};

  always #4 aclk = ~aclk;

  flash_protect_status u_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .nv_valid, .nv_prot, .eng_take, .eng_busy, .verify_done, .verify_erased,
    .stop_req, .cmd_valid, .cmd, .irq
  );
  engine_model u_eng (
    .aclk, .aresetn, .cmd_valid, .cmd, .slow, .erased, .eng_take, .eng_busy,
    .verify_done, .verify_erased
  );

  ////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_compared++;
    if (g !== ex) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // Normal mode hides fail and done
  task automatic chk_st(input string nm);
    rd(A_ST);
    chk(nm, {24'h0, 8'(st) & (spc ? 8'hF7 : 8'hF4)}, rdv);
  endtask

  task automatic reset_nv(input logic [7:0] v);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    nv_prot <= v;
    nv_valid <= 1'b1;
    @(posedge aclk);
    nv_valid <= 1'b0;
    st = 8'hC1;
    spc = 1'b0;
  endtask

  task automatic seq(input logic [15:0] a, input logic [7:0] cd);
    wr(A_AR, {16'h0, a});
    wr(A_CM, {24'h0, cd});
    wr(A_ST, 32'h80);
  endtask

  // Launch, check the buffered command, read status while busy, optional stop
  task automatic run(input logic [15:0] a, input logic [7:0] cd, input logic stp);
    seq(a, cd);
    @(posedge aclk);
    chk("command out", {7'h0, 1'b1, cd & 8'h65, a}, {7'h0, cmd_valid, cmd});
    chk("irq launched", 32'h0, {31'h0, irq});
    while (!eng_busy) @(posedge aclk);
    st = 8'h80;
    chk_st("busy");
    stop_req <= stp;
    @(posedge aclk);
    stop_req <= 1'b0;
    while (eng_busy) @(posedge aclk);
    repeat (3) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    close_out();
  end

  initial begin
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        r = $random(seed);
        nv = {f[2], 1'b1, f[0], r[4:3], f[1], r[1:0]};
        w8 = {t[2], 1'b1, t[0], r[12:11], t[1], r[9:8]};
        reset_nv(nv);
        rd(A_PR);
        chk("prot load", {24'h0, nv & 8'hBF}, rdv & 32'hFFFF_FFBF);
        e = {w8[7], 1'b0, w8[5], nv[5] ? w8[4:3] : nv[4:3], w8[2], nv[2] ? w8[1:0] : nv[1:0]};
        e = allow[f][t] ? e : nv & 8'hBF;
        wr(A_PR, {24'h0, w8});
        rd(A_PR);
        chk("prot move", {24'h0, e}, rdv & 32'hFFFF_FFBF);
      end
    end
    $display("test protection moves done");
    for (int s = 0; s < 8; s++) begin
      r = $random(seed);
      nv = {s[2], 1'b1, s[0], r[4:3], s[1], r[1:0]};
      reset_nv(nv);
      for (int j = 0; j < 4; j++) begin
        pa = (j == 0) ? hb[nv[4:3]] : (j == 1) ? hb[nv[4:3]] - 16'h2 :
             (j == 2) ? le[nv[1:0]] - 16'h1 : le[nv[1:0]] + 16'h1;
        hit = ((!nv[5] && pa >= hb[nv[4:3]]) ||
               (!nv[2] && pa >= 16'h4000 && pa <= le[nv[1:0]])) ^ !nv[7];
        wr(A_AR, {16'h0, pa});
        wr(A_CM, 32'h20);
        wr(A_ST, 32'h0);
        st = hit ? 8'hE1 : 8'hD1;
        chk_st("probe");
        wr(A_ST, hit ? 32'h20 : 32'h10);
        st = 8'hC1;
        chk_st("flag clear");
      end
    end
    $display("test protection ranges done");
    reset_nv(8'hFF);
    chk_st("reset status");
    rd(A_CF);
    chk("config reset", 32'h0, rdv);
    wr(A_ST, 32'h0E);
    chk_st("ignored bits");
    rd(8'h3C);
    chk("unmapped read", 32'h2, {30'h0, rsp});
    chk("unmapped data", 32'h0, rdv);
    wr(8'h3C, 32'hFF);
    chk("unmapped write", 32'h2, {30'h0, rsp});
    wr(A_CF, 32'hC0);
    for (int i = 0; i < 7; i++) begin
      c = codes[i] & 8'h65;
      slow <= i[0];
      @(posedge aclk);
      chk("irq idle", 32'h1, {31'h0, irq});
      if (c inside {8'h05, 8'h20, 8'h40, 8'h41}) begin
        run(16'h4000 + 16'(2 * i), codes[i], 1'b0);
        st = (c == 8'h05) ? 8'hC5 : 8'hC1;
      end else begin
        seq(16'h4000, codes[i]);
        st = st | 8'h10;
      end
      chk_st("after command");
      wr(A_ST, 32'h10);
      st = st & 8'hEF;
    end
    for (int k = 0; k < 3; k++) begin
      wr(A_CF, 32'(k) << 6);
      @(posedge aclk);
      chk("irq mask", 32'(k != 0), {31'h0, irq});
    end
    $display("test launch and interrupts done");
    run(16'h4100, 8'h20, 1'b1);
    st = 8'hD1;
    chk_st("stop");
    seq(16'h4100, 8'h20);
    @(posedge aclk);
    chk("error blocks", 32'h0, {31'h0, cmd_valid});
    wr(A_ST, 32'h10);
    st = 8'hC1;
    wr(A_CF, 32'h01);
    spc = 1'b1;
    erased <= 1'b0;
    run(16'h4000, 8'h05, 1'b0);
    st = 8'hC3;
    chk_st("verify miss");
    seq(16'h4000, 8'h20);
    @(posedge aclk);
    chk("fail blocks", 32'h0, {31'h0, cmd_valid});
    wr(A_ST, 32'h01);
    chk_st("done read only");
    wr(A_ST, 32'h02);
    st = 8'hC1;
    chk_st("fail cleared");
    erased <= 1'b1;
    run(16'h4000, 8'h05, 1'b0);
    st = 8'hC5;
    chk_st("verify hit");
    $display("test stop and special mode done");
    close_out();
  end
endmodule // test_flash_protect_status
